//--- rtl/pms_sequencer.sv
// Power-mode sequencer: Active, Power Save, Idle and Halt with clock qualification.
// Assumes clk_sys is the slow clock, all inputs synchronous to it, and a
// clock generator that reports oscillator and PLL stability as levels.
//
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none

module pms_sequencer
  import pms_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [PMS_ADDR_W-1:0] addr,
  input  wire logic [PMS_DATA_W-1:0] wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [PMS_DATA_W-1:0] rd_data,
  input  wire pms_clk_stat_t         clk_stat,
  input  wire logic                  pll_power_down,
  input  wire logic                  lf_xtal_absent,
  input  wire logic                  cpu_wait,
  input  wire logic                  nmi_wake,
  input  wire logic                  wakeup_input,
  input  wire logic                  int_ack,
  output pms_mode_t                  power_mode,
  output pms_clk_ctl_t               clk_ctl,
  output logic                       wake_pending
);

  pms_state_t  r;
  pms_state_t  next_r;
  pms_status_t status;
  pms_ctrl_t   wc;
  logic        pll_ok;
  logic        waiting;
  logic        entry_req;
  logic        wake;
  logic        sw_go_save;
  logic        sw_go_active;

  pms_wake_latch u_wake (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .wake_evt (nmi_wake | wakeup_input),
    .int_ack  (int_ack),
    .pending  (wake_pending)
  );

  // a disabled PLL counts as stable
  assign pll_ok = clk_stat.pll_stable | ~r.clk.pll_en;

  // live clock status, upper bits zero
  assign status = '{
    rsvd:      PMS_STATUS_RSVD,
    pll_ok:    pll_ok,
    hf_osc_ok: clk_stat.hf_stable,
    lf_osc_ok: clk_stat.lf_stable
  };

  always_comb begin
    next_r       = r;
    wc           = pms_ctrl_t'(wr_data);
    sw_go_save   = 1'b0;
    sw_go_active = 1'b0;
    next_r.rd_data = PMS_RD_UNMAPPED;

    // Register reads, data stand one cycle later
    if (rd_en) begin
      case (addr)
        PMS_REG_CTRL: begin
          next_r.rd_data = r.ctrl;
        end
        PMS_REG_STATUS: begin
          next_r.rd_data = status;
        end
        default: begin
          next_r.rd_data = PMS_RD_UNMAPPED;
        end
      endcase
    end

    // Software writes to the control register
    if (wr_en && (addr == PMS_REG_CTRL)) begin
      next_r.ctrl.rsvd                  = PMS_CTRL_RSVD;
      next_r.ctrl.idle                  = wc.idle;
      next_r.ctrl.halt                  = wc.halt;
      next_r.ctrl.wait_gated_transition = wc.wait_gated_transition;
      // separate disables for oscillator and PLL
      next_r.ctrl.hf_osc_disable        = wc.hf_osc_disable;
      next_r.ctrl.pll_disable           = wc.pll_disable;
      if (wc.power_save_bit) begin
        if (wc.wait_gated_transition) begin
          // bit set at once, entry waits
          next_r.ctrl.power_save_bit = 1'b1;
        end else if (!r.ctrl.power_save_bit && (r.mode == ST_ACTIVE)) begin
          sw_go_save = 1'b1;
        end
      end else if (r.mode == ST_SAVE) begin
        // bit stays set until Active reached
        sw_go_active = 1'b1;
      end else if (r.mode == ST_ACTIVE) begin
        next_r.ctrl.power_save_bit = 1'b0;
      end
    end

    wake      = wake_pending && pms_is_low_power(r.mode);
    waiting   = r.wait_seen || cpu_wait;
    entry_req = next_r.ctrl.wait_gated_transition &&
                (next_r.ctrl.halt || next_r.ctrl.idle ||
                 (next_r.ctrl.power_save_bit && (r.mode == ST_ACTIVE)));
    next_r.wait_seen = 1'b0;

    case (r.mode)
      ST_ACTIVE, ST_SAVE: begin
        if (wake) begin
          next_r.mode                = ST_WAKE_HF;
          next_r.ctrl.hf_osc_disable = 1'b0;
          next_r.ctrl.idle           = 1'b0;
        end else if (waiting && entry_req) begin
          if (clk_stat.lf_stable) begin
            // Idle entered from Active or Save at WAIT
            // Halt entered from Active or Save at WAIT
            if (next_r.ctrl.halt) begin
              next_r.mode = ST_HALT;
            end else if (next_r.ctrl.idle) begin
              next_r.mode = ST_IDLE;
            end else begin
              next_r.mode = ST_SAVE;
            end
          end else begin
            // held back without the low-frequency clock
            // WAIT kept pending until status set
            next_r.wait_seen = 1'b1;
          end
        end else if (sw_go_save) begin
          // immediate switch, CPU on slow clock
          next_r.mode = ST_GO_SAVE;
        end else if (sw_go_active) begin
          next_r.mode = ST_GO_ACTIVE;
        end
      end
      ST_GO_SAVE: begin
        // Power Save waits for the low-frequency clock
        // bit set once the switch completes
        if (clk_stat.lf_stable) begin
          next_r.mode                = ST_SAVE;
          next_r.ctrl.power_save_bit = 1'b1;
        end
      end
      ST_IDLE, ST_HALT: begin
        if (wake) begin
          // Idle and Halt return on wake-up
          next_r.mode                = ST_WAKE_HF;
          next_r.ctrl.hf_osc_disable = 1'b0;
          next_r.ctrl.idle           = 1'b0;
        end
      end
      ST_WAKE_HF: begin
        if (clk_stat.hf_stable) begin
          next_r.mode             = ST_WAKE_PLL;
          next_r.ctrl.pll_disable = 1'b0;
          next_r.ctrl.halt        = 1'b0;
        end
      end
      ST_WAKE_PLL: begin
        // wait PLL, then switch to Active
        // only clocks restored, CPU left waiting
        if (pll_ok && clk_stat.hf_stable) begin
          next_r.mode                = ST_ACTIVE;
          next_r.ctrl.power_save_bit = 1'b0;
        end
      end
      ST_GO_ACTIVE: begin
        // software return waits for both clocks
        // bit clears together with Active entry
        if (clk_stat.hf_stable && pll_ok) begin
          next_r.mode                = ST_ACTIVE;
          next_r.ctrl.power_save_bit = 1'b0;
        end else if (wake_pending) begin
          next_r.mode = ST_WAKE_HF;
          next_r.ctrl.hf_osc_disable = 1'b0;
          next_r.ctrl.idle           = 1'b0;
        end
      end
      default: begin
        next_r.mode = ST_ACTIVE;
      end
    endcase

    // Clock controls follow the mode being entered
    // disables act only once Save or Idle reached
    // oscillator forced on in Active, off in Halt
    // without a crystal, main clock stops only in Halt
    if (next_r.mode == ST_HALT) begin
      next_r.clk.hf_osc_en = 1'b0;
    end else if (pms_is_gated(next_r.mode)) begin
      next_r.clk.hf_osc_en = ~next_r.ctrl.hf_osc_disable | lf_xtal_absent;
    end else begin
      next_r.clk.hf_osc_en = 1'b1;
    end
    // PLL gated by its own disable bit, by pll_power_down and in Halt
    if (next_r.mode == ST_HALT) begin
      next_r.clk.pll_en = 1'b0;
    end else if (pms_is_gated(next_r.mode)) begin
      next_r.clk.pll_en = ~next_r.ctrl.pll_disable & ~pll_power_down;
    end else begin
      next_r.clk.pll_en = ~pll_power_down;
    end
    next_r.clk.sys_clk_en      = (next_r.mode != ST_IDLE) && (next_r.mode != ST_HALT);
    next_r.clk.slow_clk_en     = (next_r.mode != ST_HALT);
    next_r.clk.cpu_on_slow_clk = (next_r.mode == ST_SAVE) || (next_r.mode == ST_GO_SAVE) ||
                                 (next_r.mode == ST_GO_ACTIVE);
    // slow clock from main clock without a crystal
    next_r.clk.slow_from_main  = lf_xtal_absent;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r.mode      <= ST_ACTIVE;
      r.ctrl      <= pms_ctrl_t'(PMS_CTRL_RESET);
      r.wait_seen <= 1'b0;
      r.rd_data   <= PMS_RD_UNMAPPED;
      r.clk       <= PMS_CLK_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data    = r.rd_data;
  assign power_mode = r.mode;
  assign clk_ctl    = r.clk;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_status_read: assert property (
    rd_en && (addr == PMS_REG_STATUS) |=>
      rd_data == {PMS_STATUS_RSVD, $past(pll_ok), $past(clk_stat.hf_stable),
                  $past(clk_stat.lf_stable)})
    else $error("status read does not match clock status");

  a_lf_gate_entry: assert property (
    !pms_is_low_power(r.mode) ##1 pms_is_low_power(r.mode) |-> $past(clk_stat.lf_stable))
    else $error("low-power mode entered without low-frequency clock");

  a_active_hf_ok: assert property (
    (r.mode != ST_ACTIVE) ##1 (r.mode == ST_ACTIVE) |-> $past(clk_stat.hf_stable))
    else $error("Active entered with oscillator unstable");

  a_active_pll_ok: assert property (
    (r.mode != ST_ACTIVE) ##1 (r.mode == ST_ACTIVE) |-> $past(pll_ok))
    else $error("Active entered with PLL unstable");

  a_wake_held: assert property (
    wake_pending && !int_ack |=> wake_pending)
    else $error("wake-up event lost before acknowledge");

  a_wait_gating: assert property (
    (r.mode == ST_ACTIVE) && r.ctrl.wait_gated_transition && !r.wait_seen &&
      !cpu_wait && !wr_en && !wake_pending |=> (r.mode == ST_ACTIVE))
    else $error("gated transition left Active without WAIT");

  a_idle_origin: assert property (
    (r.mode != ST_IDLE) ##1 (r.mode == ST_IDLE) |->
      ($past(r.mode) == ST_ACTIVE) || ($past(r.mode) == ST_SAVE))
    else $error("Idle entered from an illegal mode");

  a_osc_by_mode: assert property (
    ((r.mode == ST_ACTIVE) |-> clk_ctl.hf_osc_en) and ((r.mode == ST_HALT) |-> !clk_ctl.hf_osc_en))
    else $error("oscillator enable wrong for mode");

  a_psm_holds: assert property (
    (r.mode == ST_GO_ACTIVE) |-> r.ctrl.power_save_bit)
    else $error("power-save bit cleared before Active");

  a_wake_exit: assert property (
    wake_pending && pms_is_low_power(r.mode) |=> (r.mode == ST_WAKE_HF) && !r.ctrl.idle)
    else $error("wake-up did not start the return to Active");

  a_wake_order: assert property (
    (r.mode == ST_WAKE_HF) ##1 (r.mode == ST_WAKE_PLL) |->
      !r.ctrl.pll_disable && !r.ctrl.hf_osc_disable && $past(clk_stat.hf_stable))
    else $error("wake-up steps out of order");

  a_main_kept: assert property (
    lf_xtal_absent && pms_is_gated(r.mode) && $past(lf_xtal_absent) |-> clk_ctl.hf_osc_en)
    else $error("main clock stopped without a crystal");

  a_halt_origin: assert property (
    (r.mode != ST_HALT) ##1 (r.mode == ST_HALT) |->
      ($past(r.mode) == ST_ACTIVE) || ($past(r.mode) == ST_SAVE))
    else $error("Halt entered from an illegal mode");

  a_save_bit_set: assert property (
    (r.mode == ST_GO_SAVE) ##1 (r.mode == ST_SAVE) |-> r.ctrl.power_save_bit)
    else $error("power-save bit not set on Save entry");

  a_osc_before_entry: assert property (
    !pms_is_gated(r.mode) && (r.mode != ST_HALT) |-> clk_ctl.hf_osc_en)
    else $error("oscillator stopped outside Save, Idle or Halt");

endmodule

`default_nettype wire

//--- rtl/pms_pkg.sv
// Shared types and constants of the power-mode sequencer.
// Assumes a single slow clock domain and a byte-wide register port.
`default_nettype none

package pms_pkg;

  // Register port
  localparam int unsigned PMS_ADDR_W      = 4;
  localparam int unsigned PMS_DATA_W      = 8;
  localparam logic [3:0]  PMS_REG_CTRL    = 4'h0;
  localparam logic [3:0]  PMS_REG_STATUS  = 4'h1;
  localparam logic [7:0]  PMS_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  PMS_RD_UNMAPPED = 8'h00;
  localparam logic [4:0]  PMS_STATUS_RSVD = 5'h00;
  localparam logic [1:0]  PMS_CTRL_RSVD   = 2'h0;

  // Power modes and the transitional steps between them
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_GO_SAVE,
    ST_SAVE,
    ST_IDLE,
    ST_HALT,
    ST_WAKE_HF,
    ST_WAKE_PLL,
    ST_GO_ACTIVE
  } pms_mode_t;

  // Control register layout, bit 0 first from the right
  typedef struct packed {
    logic [1:0] rsvd;
    logic       pll_disable;
    logic       hf_osc_disable;
    logic       wait_gated_transition;
    logic       halt;
    logic       idle;
    logic       power_save_bit;
  } pms_ctrl_t;

  // Status register layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic       pll_ok;
    logic       hf_osc_ok;
    logic       lf_osc_ok;
  } pms_status_t;

  // Stability reports from the clock generator
  typedef struct packed {
    logic lf_stable;
    logic hf_stable;
    logic pll_stable;
  } pms_clk_stat_t;

  // Clock controls towards the clock generator
  typedef struct packed {
    logic sys_clk_en;
    logic slow_clk_en;
    logic hf_osc_en;
    logic pll_en;
    logic cpu_on_slow_clk;
    logic slow_from_main;
  } pms_clk_ctl_t;

  localparam pms_clk_ctl_t PMS_CLK_RESET = '{
    sys_clk_en:      1'b1,
    slow_clk_en:     1'b1,
    hf_osc_en:       1'b1,
    pll_en:          1'b1,
    cpu_on_slow_clk: 1'b0,
    slow_from_main:  1'b0
  };

  typedef struct packed {
    pms_mode_t    mode;
    pms_ctrl_t    ctrl;
    logic         wait_seen;
    logic [7:0]   rd_data;
    pms_clk_ctl_t clk;
  } pms_state_t;

  typedef struct packed {
    logic pending;
  } pms_wake_t;

  // Low-power modes; a wake-up event is acted upon in these and in ST_GO_ACTIVE
  function automatic logic pms_is_low_power(input pms_mode_t m);
    return (m == ST_SAVE) || (m == ST_IDLE) || (m == ST_HALT);
  endfunction

  // Modes in which the clock-disable bits take effect
  function automatic logic pms_is_gated(input pms_mode_t m);
    return (m == ST_SAVE) || (m == ST_IDLE);
  endfunction

endpackage

`default_nettype wire

//--- rtl/pms_wake_latch.sv
// Sticky wake-up event latch.
// Assumes event and acknowledge inputs synchronous to clk_sys.
`default_nettype none

module pms_wake_latch
  import pms_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic wake_evt,
  input  wire logic int_ack,
  output logic      pending
);

  pms_wake_t r;
  pms_wake_t next_r;

  always_comb begin
    next_r = r;
    if (int_ack) begin
      next_r.pending = 1'b0;
    end
    if (wake_evt) begin
      next_r.pending = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r.pending <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign pending = r.pending;

endmodule

`default_nettype wire

//--- dv/pms_clkgen_model.sv
// Behavioural clock generator facing the power-mode sequencer.
// Assumes clk_ctl levels from the sequencer; lf_good is steered by the bench.
`default_nettype none

module pms_clkgen_model
  import pms_pkg::*;
#(
  parameter int HF_DLY  = 3,
  parameter int PLL_DLY = 5
)(
  input  wire logic          clk_sys,
  input  wire logic          lf_good,
  input  wire pms_clk_ctl_t  clk_ctl,
  output var pms_clk_stat_t  clk_stat
);
  timeunit 1ns;
  timeprecision 1ns;

  int hf_cnt  = 0;
  int pll_cnt = 0;

  // A stopped source loses its stable report one clock after its enable drops, a started one settles late
  always @(posedge clk_sys) begin
    hf_cnt  <= clk_ctl.hf_osc_en ? hf_cnt + 1 : 0;
    pll_cnt <= clk_ctl.pll_en ? pll_cnt + 1 : 0;
  end

  assign clk_stat = '{
    lf_stable:  lf_good,
    hf_stable:  (hf_cnt >= HF_DLY),
    pll_stable: (pll_cnt >= PLL_DLY)
  };
endmodule

`default_nettype wire

//--- dv/power_mode_sequencer_tb.sv
// Self-checking bench of the power-mode sequencer.
// Assumes a behavioural clock generator model; the bench acts as CPU and wake sources.
`default_nettype none

module power_mode_sequencer_tb
  import pms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          clk_sys = 1'b0;
  logic          srst    = 1'b1;
  logic [3:0]    addr    = 4'h0;
  logic [7:0]    wr_data = 8'h00;
  logic          wr_en   = 1'b0;
  logic          rd_en   = 1'b0;
  logic [7:0]    rd_data;
  pms_clk_stat_t clk_stat;
  logic          pll_pd  = 1'b0;
  logic          no_xtal = 1'b0;
  logic          cpu_wait = 1'b0;
  logic          nmi     = 1'b0;
  logic          wk_in   = 1'b0;
  logic          int_ack = 1'b0;
  logic          lf_good = 1'b1;
  pms_mode_t     power_mode;
  pms_clk_ctl_t  clk_ctl;
  logic          wake_pending;
  int            n_mismatch = 0;
  int            cmp_count  = 0;
  logic [7:0]    rv;
  logic [3:0]    r_a [5];
  logic [7:0]    r_w [5];
  logic [7:0]    r_e [5];

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  pms_sequencer u_dut (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .clk_stat(clk_stat), .pll_power_down(pll_pd),
    .lf_xtal_absent(no_xtal), .cpu_wait(cpu_wait), .nmi_wake(nmi), .wakeup_input(wk_in),
    .int_ack(int_ack), .power_mode(power_mode), .clk_ctl(clk_ctl),
    .wake_pending(wake_pending)
  );

  pms_clkgen_model #(.HF_DLY(3), .PLL_DLY(5)) u_clk (
    .clk_sys(clk_sys), .lf_good(lf_good), .clk_ctl(clk_ctl), .clk_stat(clk_stat)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // One-cycle pulse on {int_ack, nmi, wk_in, cpu_wait}
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    {int_ack, nmi, wk_in, cpu_wait} <= m;
    @(posedge clk_sys);
    {int_ack, nmi, wk_in, cpu_wait} <= 4'h0;
  endtask

  task automatic wait_mode(input pms_mode_t m);
    int i;
    #1;
    for (i = 0; i < 60 && power_mode !== m; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (power_mode !== m) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, power_mode, m);
      wrap_up();
    end
  endtask

  initial begin
    r_a = '{4'h0, 4'h0, 4'h0, 4'h5, 4'h1};
    r_w = '{8'h3e, 8'hc8, 8'h00, 8'hff, 8'hf8};
    r_e = '{8'h3e, 8'h08, 8'h00, 8'h00, 8'h07};
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({5'h0, power_mode}, {5'h0, ST_ACTIVE});
    chk({2'h0, clk_ctl}, {2'h0, PMS_CLK_RESET});
    rd(PMS_REG_CTRL, rv);
    chk(rv, PMS_CTRL_RESET);
    $display("test reset done");

    for (int i = 0; i < 5; i++) begin
      wr(r_a[i], r_w[i]);
      rd(r_a[i], rv);
      chk(rv, r_e[i]);
    end
    $display("test register table done");

    // PLL power-down acts in Active too and counts as a stable PLL
    @(posedge clk_sys);
    pll_pd <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h0, clk_ctl.pll_en}, 8'h00);
    rd(PMS_REG_STATUS, rv);
    chk(rv, 8'h07);
    @(posedge clk_sys);
    pll_pd <= 1'b0;

    // Immediate entry held off until the low-frequency clock is good
    lf_good <= 1'b0;
    wr(PMS_REG_CTRL, 8'h01);
    wait_mode(ST_GO_SAVE);
    repeat (4) @(posedge clk_sys);
    rd(PMS_REG_STATUS, rv);
    chk(rv, 8'h06);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h00);
    // Low-frequency clock made good, Save reached on slow clock with the bit set
    lf_good <= 1'b1;
    wait_mode(ST_SAVE);
    chk({7'h0, clk_ctl.cpu_on_slow_clk}, 8'h01);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h01);
    wr(PMS_REG_CTRL, 8'h31);
    @(posedge clk_sys);
    #1;
    chk({6'h0, clk_ctl.hf_osc_en, clk_ctl.pll_en}, 8'h00);
    rd(PMS_REG_STATUS, rv);
    chk(rv, 8'h05);
    // Oscillator back on and settled before leaving Save, PLL kept off
    wr(PMS_REG_CTRL, 8'h21);
    repeat (8) @(posedge clk_sys);
    wr(PMS_REG_CTRL, 8'h00);
    wait_mode(ST_GO_ACTIVE);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h01);
    wait_mode(ST_ACTIVE);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h00);
    $display("test power save done");

    wr(PMS_REG_CTRL, 8'h3c);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({5'h0, power_mode}, {5'h0, ST_ACTIVE});
    chk({7'h0, clk_ctl.hf_osc_en}, 8'h01);
    pulse(4'h1);
    wait_mode(ST_HALT);
    chk({2'h0, clk_ctl}, {2'h0, 6'h00});
    pulse(4'h2);
    wait_mode(ST_WAKE_HF);
    chk({7'h0, clk_ctl.hf_osc_en}, 8'h01);
    wait_mode(ST_WAKE_PLL);
    wait_mode(ST_ACTIVE);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h08);
    repeat (5) @(posedge clk_sys);
    chk({7'h0, wake_pending}, 8'h01);
    pulse(4'h8);
    #1;
    chk({7'h0, wake_pending}, 8'h00);
    $display("test halt wake done");

    no_xtal <= 1'b1;
    wr(PMS_REG_CTRL, 8'h1a);
    pulse(4'h1);
    wait_mode(ST_IDLE);
    chk({6'h0, clk_ctl.sys_clk_en, clk_ctl.hf_osc_en}, 8'h01);
    chk({7'h0, clk_ctl.slow_from_main}, 8'h01);
    pulse(4'h4);
    wait_mode(ST_ACTIVE);
    chk({7'h0, clk_ctl.slow_from_main}, 8'h01);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h08);
    pulse(4'h8);
    no_xtal <= 1'b0;
    $display("test idle wake done");

    wr(PMS_REG_CTRL, 8'h09);
    pulse(4'h1);
    wait_mode(ST_SAVE);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({5'h0, power_mode}, {5'h0, ST_ACTIVE});
    chk({2'h0, clk_ctl}, {2'h0, PMS_CLK_RESET});
    rd(PMS_REG_STATUS, rv);
    chk(rv, 8'h07);
    rd(PMS_REG_CTRL, rv);
    chk(rv, 8'h00);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
